// ===== src/eis_map.vh
`ifndef EIS_MAP_VH
`define EIS_MAP_VH

// ********************************************************
// Register byte addresses
// ********************************************************
`define EIS_ADDR_FLAGS    32'he01f_c140
`define EIS_ADDR_MODE     32'he01f_c148
`define EIS_ADDR_POLARITY 32'he01f_c14c
`define EIS_ADDR_MASK     32'he01f_c150

// ********************************************************
// Field layout and reset values
// ********************************************************
`define EIS_NCH           4
`define EIS_FIELD_MSB     3
`define EIS_NPIN          9
`define EIS_RST_MODE      4'h0
`define EIS_RST_POLARITY  4'h0
`define EIS_RST_MASK      4'h0
`define EIS_RST_FLAGS     4'h0

// ********************************************************
// Pin slices per channel
// ********************************************************
`define EIS_CH0_LSB       0
`define EIS_CH1_LSB       2
`define EIS_CH2_LSB       4
`define EIS_CH3_LSB       6

// ********************************************************
// Bus answers
// ********************************************************
`define EIS_RESP_OKAY     2'h0
`define EIS_RESP_SLVERR   2'h2

`endif

// ===== src/eis_combiner.v
// Function
// R1 - Per-channel mode bit: 0 level, 1 edge
// R2 - Polarity bit: 0 low/falling, 1 high/rising
// R3 - Upper bits 7:4 of mode/polarity undefined
// R4 - Software writes no ones to bits 7:4
// R5 - Request only from selected pins, enabled channels; combined_irq_request_o is not gated by the enable mask
// R6 - Software disables channel before changing polarity
// R7 - Polarity change may set flag; tolerated
// R8 - Combiner sees pin levels and selects
// R9 - Level low-active: AND selected pins
// R10 - Level high-active: OR selected pins
// R11 - Edge mode: lowest selected pin only
// R12 - Software selects one pin in edge mode
// R13 - Handler reads port levels for source
// R14 - Flag set on active level or edge
// R15 - Write one clears flag unless level active
// R16 - Synchronise inputs, compare with previous sample
`timescale 1ns/100ps
`default_nettype none
`include "eis_map.vh"

// ********************************************************
// One channel: combine, detect, flag
// ********************************************************
module eis_chan #(
  parameter NPIN = 2
) (
  // Clock and reset
  input  wire            sys_clk_i,
  input  wire            rstn_i,
  // Pins, already synchronised
  input  wire [NPIN-1:0] pin_i,
  input  wire [NPIN-1:0] sel_i,
  // Configuration
  input  wire            edge_i,
  input  wire            pol_i,
  input  wire            clr_i,
  // Results
  output reg             flag_o,
  output reg             comb_o
);

  reg  lowest;
  reg  prev_q;
  wire any_sel;
  wire and_v;
  wire or_v;
  wire lvl_act;
  wire edge_act;
  wire edge_hit;
  wire flag_d;
  integer i;

  // Unselected pins are neutral for both gates
  assign any_sel = |sel_i;                                // see R8
  assign and_v   = &(pin_i | ~sel_i);                     // see R9
  assign or_v    = |(pin_i & sel_i);                      // see R10
  assign lvl_act = any_sel & (pol_i ? or_v : ~and_v);     // see R2

  // Descending scan leaves the lowest selected pin
  always @* begin
    lowest = 1'b0;
    for (i = NPIN - 1; i >= 0; i = i - 1) begin
      if (sel_i[i]) begin
        lowest = pin_i[i];                                // see R11
      end
    end
  end

  // Edge seen on the polarity-adjusted level, so a polarity
  // flip can raise a flag; software clears it afterwards
  assign edge_act = any_sel & (pol_i ? lowest : ~lowest); // see R2
  assign edge_hit = edge_act & ~prev_q;                   // see R7

  // Set wins over clear, which keeps a level flag up
  assign flag_d = (edge_i ? edge_hit : lvl_act)           // see R1
                | (flag_o & ~clr_i);                      // see R15

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_q <= 1'b0;
      flag_o <= 1'b0;
      comb_o <= 1'b0;
    end else begin
      prev_q <= edge_act;                                 // see R16
      flag_o <= flag_d;                                   // see R14
      comb_o <= edge_i ? edge_act : lvl_act;
    end
  end

endmodule

// ********************************************************
// Top: pin sync, registers, AXI4-Lite slave
// ********************************************************
module eis_combiner (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        rstn_i,
  // Pins and pin-mux selects
  input  wire [8:0]  pin_levels_i,
  input  wire [8:0]  pin_func_sel_i,
  // Interrupt controller enable mask
  input  wire [3:0]  vector_irq_enable_mask_i,
  // AXI4-Lite write address
  input  wire [31:0] s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output reg         s_axi_awready_o,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output reg         s_axi_wready_o,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  // AXI4-Lite read address
  input  wire [31:0] s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output reg         s_axi_arready_o,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  // Results
  output reg  [3:0]  ext_irq_req_o,
  output reg  [3:0]  combined_irq_request_o,
  output reg         irq_o
);

  reg  [8:0]  pin_meta_q;
  reg  [8:0]  pin_sync_q;
  reg  [3:0]  edge_select_q;
  reg  [3:0]  polarity_select_q;
  reg  [3:0]  irq_mask_q;
  reg         aw_hold_q;
  reg  [31:0] awaddr_q;
  reg         w_hold_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg  [31:0] rdata_d;
  reg  [1:0]  rresp_d;
  wire        wr_go;
  wire        wr_hit;
  wire        wr_lane0;
  wire [3:0]  flag_clr;
  wire [3:0]  ext_irq_flags;
  wire [3:0]  comb_req;

  // ********************************************************
  // Pin synchroniser
  // ********************************************************
  // Pins are asynchronous; the first stage feeds only the second
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta_q <= 9'h000;
      pin_sync_q <= 9'h000;
    end else begin
      pin_meta_q <= pin_levels_i;                         // see R16
      pin_sync_q <= pin_meta_q;
    end
  end

  // ********************************************************
  // Channels
  // ********************************************************
  eis_chan #(.NPIN(2)) u_ext_irq_channel_0 (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .pin_i     (pin_sync_q[`EIS_CH0_LSB+1:`EIS_CH0_LSB]),
    .sel_i     (pin_func_sel_i[`EIS_CH0_LSB+1:`EIS_CH0_LSB]),
    .edge_i    (edge_select_q[0]),
    .pol_i     (polarity_select_q[0]),
    .clr_i     (flag_clr[0]),
    .flag_o    (ext_irq_flags[0]),
    .comb_o    (comb_req[0])
  );
  eis_chan #(.NPIN(2)) u_ext_irq_channel_1 (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .pin_i     (pin_sync_q[`EIS_CH1_LSB+1:`EIS_CH1_LSB]),
    .sel_i     (pin_func_sel_i[`EIS_CH1_LSB+1:`EIS_CH1_LSB]),
    .edge_i    (edge_select_q[1]),
    .pol_i     (polarity_select_q[1]),
    .clr_i     (flag_clr[1]),
    .flag_o    (ext_irq_flags[1]),
    .comb_o    (comb_req[1])
  );
  eis_chan #(.NPIN(2)) u_ext_irq_channel_2 (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .pin_i     (pin_sync_q[`EIS_CH2_LSB+1:`EIS_CH2_LSB]),
    .sel_i     (pin_func_sel_i[`EIS_CH2_LSB+1:`EIS_CH2_LSB]),
    .edge_i    (edge_select_q[2]),
    .pol_i     (polarity_select_q[2]),
    .clr_i     (flag_clr[2]),
    .flag_o    (ext_irq_flags[2]),
    .comb_o    (comb_req[2])
  );
  eis_chan #(.NPIN(3)) u_ext_irq_channel_3 (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .pin_i     (pin_sync_q[`EIS_CH3_LSB+2:`EIS_CH3_LSB]),
    .sel_i     (pin_func_sel_i[`EIS_CH3_LSB+2:`EIS_CH3_LSB]),
    .edge_i    (edge_select_q[3]),
    .pol_i     (polarity_select_q[3]),
    .clr_i     (flag_clr[3]),
    .flag_o    (ext_irq_flags[3]),
    .comb_o    (comb_req[3])
  );

  // ********************************************************
  // Write channel
  // ********************************************************
  assign wr_go    = aw_hold_q & w_hold_q & ~s_axi_bvalid_o;
  assign wr_lane0 = wr_go & wstrb_q[0];
  assign wr_hit   = (awaddr_q == `EIS_ADDR_FLAGS)
                  | (awaddr_q == `EIS_ADDR_MODE)
                  | (awaddr_q == `EIS_ADDR_POLARITY)
                  | (awaddr_q == `EIS_ADDR_MASK);
  assign flag_clr = (wr_lane0 && awaddr_q == `EIS_ADDR_FLAGS) ?
                    wdata_q[`EIS_FIELD_MSB:0] : 4'h0;     // see R15

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_hold_q         <= 1'b0;
      awaddr_q          <= 32'h0000_0000;
      w_hold_q          <= 1'b0;
      wdata_q           <= 32'h0000_0000;
      wstrb_q           <= 4'h0;
      s_axi_awready_o   <= 1'b1;
      s_axi_wready_o    <= 1'b1;
      s_axi_bvalid_o    <= 1'b0;
      s_axi_bresp_o     <= `EIS_RESP_OKAY;
      edge_select_q     <= `EIS_RST_MODE;
      polarity_select_q <= `EIS_RST_POLARITY;
      irq_mask_q        <= `EIS_RST_MASK;
    end else begin
      // Address and data taken in either order
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold_q       <= 1'b1;
        awaddr_q        <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold_q       <= 1'b1;
        wdata_q        <= s_axi_wdata_i;
        wstrb_q        <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_q      <= 1'b0;
        w_hold_q       <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? `EIS_RESP_OKAY : `EIS_RESP_SLVERR;
      end
      // Readies reopen only after the response, one write at a time
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
      // Bits 7:4 are not stored; writes to them are dropped
      if (wr_lane0 && awaddr_q == `EIS_ADDR_MODE) begin
        edge_select_q <= wdata_q[`EIS_FIELD_MSB:0];       // see R1
      end
      if (wr_lane0 && awaddr_q == `EIS_ADDR_POLARITY) begin
        polarity_select_q <= wdata_q[`EIS_FIELD_MSB:0];   // see R2
      end
      if (wr_lane0 && awaddr_q == `EIS_ADDR_MASK) begin
        irq_mask_q <= wdata_q[`EIS_FIELD_MSB:0];
      end
    end
  end

  // ********************************************************
  // Read channel
  // ********************************************************
  // Undefined upper bits are given as zero
  always @* begin
    rdata_d = 32'h0000_0000;
    rresp_d = `EIS_RESP_OKAY;
    case (s_axi_araddr_i)
      `EIS_ADDR_FLAGS: begin
        rdata_d[`EIS_FIELD_MSB:0] = ext_irq_flags;
      end
      `EIS_ADDR_MODE: begin
        rdata_d[`EIS_FIELD_MSB:0] = edge_select_q;        // see R3
      end
      `EIS_ADDR_POLARITY: begin
        rdata_d[`EIS_FIELD_MSB:0] = polarity_select_q;    // see R3
      end
      `EIS_ADDR_MASK: begin
        rdata_d[`EIS_FIELD_MSB:0] = irq_mask_q;
      end
      default: begin
        rresp_d = `EIS_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `EIS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rdata_d;
        s_axi_rresp_o   <= rresp_d;
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  // Flags run regardless of the enable mask; only ext_irq_req_o is gated, combined_irq_request_o is not
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_irq_req_o          <= 4'h0;
      combined_irq_request_o <= 4'h0;
      irq_o                  <= 1'b0;
    end else begin
      ext_irq_req_o          <= ext_irq_flags & vector_irq_enable_mask_i; // see R5
      combined_irq_request_o <= comb_req;
      irq_o                  <= |(ext_irq_flags & irq_mask_q);
    end
  end
endmodule
`default_nettype wire

// ===== tb/eis_combiner_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ********************************************************
// Bus and request checks
// ********************************************************
module eis_combiner_asserts (
  // Clock and reset
  input wire        sys_clk_i,
  input wire        rstn_i,
  // Pin side
  input wire [8:0]  pin_func_sel_i,
  input wire [3:0]  vector_irq_enable_mask_i,
  // Bus side
  input wire        s_axi_awvalid_i,
  input wire        s_axi_awready_o,
  input wire        s_axi_bvalid_o,
  input wire        s_axi_bready_i,
  input wire        s_axi_arvalid_i,
  input wire        s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire        s_axi_rvalid_o,
  input wire        s_axi_rready_i,
  // Results
  input wire [3:0]  ext_irq_req_o,
  input wire [3:0]  combined_irq_request_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  chk_req_gated: assert property ((ext_irq_req_o & ~$past(vector_irq_enable_mask_i)) == 4'h0)
    else $error("request on a disabled channel");
  chk_unsel_idle: assert property ((pin_func_sel_i[1:0] == 2'h0) [*3] |-> !combined_irq_request_o[0])
    else $error("request with no pin selected");
  chk_b_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write answer dropped early");
  chk_b_reopen: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o)
    else $error("write answer not closed");
  chk_aw_closes: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
    else $error("write address open twice");
  chk_r_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  chk_r_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer changed");
  chk_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answering");
  chk_upper_zero: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:4] == 28'h000_0000)
    else $error("upper read bits set");
endmodule
bind eis_combiner eis_combiner_asserts eis_combiner_asserts_i (
  .sys_clk_i                (sys_clk_i),
  .rstn_i                   (rstn_i),
  .pin_func_sel_i           (pin_func_sel_i),
  .vector_irq_enable_mask_i (vector_irq_enable_mask_i),
  .s_axi_awvalid_i          (s_axi_awvalid_i),
  .s_axi_awready_o          (s_axi_awready_o),
  .s_axi_bvalid_o           (s_axi_bvalid_o),
  .s_axi_bready_i           (s_axi_bready_i),
  .s_axi_arvalid_i          (s_axi_arvalid_i),
  .s_axi_arready_o          (s_axi_arready_o),
  .s_axi_rdata_o            (s_axi_rdata_o),
  .s_axi_rvalid_o           (s_axi_rvalid_o),
  .s_axi_rready_i           (s_axi_rready_i),
  .ext_irq_req_o            (ext_irq_req_o),
  .combined_irq_request_o   (combined_irq_request_o)
);
`default_nettype wire

// ===== tb/eis_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
// ********************************************************
// Pin receivers and pin-mux selects
// ********************************************************
module eis_pin_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Requested state
  input  wire logic [8:0] lvl_i,
  input  wire logic [8:0] sel_i,
  // Pin side
  output var  logic [8:0] pin_o,
  output var  logic [8:0] sel_o
);
  // Idle pins rest high, nothing routed
  initial begin
    pin_o = 9'h1ff;
    sel_o = 9'h000;
  end
  always @(posedge sys_clk_i) begin
    // Same levels a handler reads back from the port
    pin_o <= lvl_i;
    sel_o <= sel_i;
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "eis_map.vh"
module tb;
  logic        sys_clk_i, rstn_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [8:0]  lvl = 9'h1ff, sel = 9'h000, pins_w, sel_w;
  logic [3:0]  ven, req, comb;
  logic [1:0]  bresp, rresp;
  logic [31:0] awaddr, wdata, araddr, rdata;
  int          bad_count = 0, cmp_count = 0;
  eis_pin_model eis_pin_model_i (.sys_clk_i(sys_clk_i), .lvl_i(lvl), .sel_i(sel), .pin_o(pins_w), .sel_o(sel_w));
  eis_combiner eis_combiner_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .pin_levels_i(pins_w),
    .pin_func_sel_i(sel_w), .vector_irq_enable_mask_i(ven), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ext_irq_req_o(req),
    .combined_irq_request_o(comb), .irq_o(irq));
  // ********************************************************
  // Helpers
  // ********************************************************
  task automatic conclude;
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // Pins need the pin model edge, 2 sync edges plus the flag edge; 8 leaves margin
  task automatic pins(input logic [8:0] v);
    @(posedge sys_clk_i);
    lvl <= v;
    cyc(8);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    chk(32'(bresp), 32'(`EIS_RESP_OKAY));
    if (!bvalid) begin
      bad_count++;
      $display("[FAIL] %0t write answer timed out", $time);
      conclude();
    end
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    chk(rdata, exp);
    chk(32'(rresp), 32'(er));
    if (!rvalid) begin
      bad_count++;
      $display("[FAIL] %0t read answer timed out", $time);
      conclude();
    end
  endtask
  // ********************************************************
  // Stimulus
  // ********************************************************
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    logic [31:0] regs [4];
    regs = '{`EIS_ADDR_FLAGS, `EIS_ADDR_MODE, `EIS_ADDR_POLARITY, `EIS_ADDR_MASK};
    rstn_i = 1'b0;
    ven = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = 96'h0;
    cyc(5);
    rstn_i <= 1'b1;
    for (int i = 0; i < 4; i++) rdc(regs[i], 32'h0000_0000, `EIS_RESP_OKAY);
    rdc(32'he01f_c144, 32'h0000_0000, `EIS_RESP_SLVERR);
    // Ch0 falling edge, ch1 level high, ch2 rising edge, ch3 level low
    wr(`EIS_ADDR_MODE, 32'h0000_0005);
    wr(`EIS_ADDR_POLARITY, 32'h0000_0006);
    rdc(`EIS_ADDR_MODE, 32'h0000_0005, `EIS_RESP_OKAY);
    rdc(`EIS_ADDR_POLARITY, 32'h0000_0006, `EIS_RESP_OKAY);
    pins(9'h1c3);
    sel <= 9'h1ff;
    cyc(8);
    wr(`EIS_ADDR_FLAGS, 32'h0000_000f);
    rdc(`EIS_ADDR_FLAGS, 32'h0000_0000, `EIS_RESP_OKAY);
    // One low pin pulls the AND low, so ch3 is already active
    pins(9'h183);
    rdc(`EIS_ADDR_FLAGS, 32'h0000_0008, `EIS_RESP_OKAY);
    pins(9'h003);
    rdc(`EIS_ADDR_FLAGS, 32'h0000_0008, `EIS_RESP_OKAY);
    wr(`EIS_ADDR_FLAGS, 32'h0000_0008);
    rdc(`EIS_ADDR_FLAGS, 32'h0000_0008, `EIS_RESP_OKAY);
    pins(9'h1c3);
    wr(`EIS_ADDR_FLAGS, 32'h0000_0008);
    rdc(`EIS_ADDR_FLAGS, 32'h0000_0000, `EIS_RESP_OKAY);
    pins(9'h1cb);
    rdc(`EIS_ADDR_FLAGS, 32'h0000_0002, `EIS_RESP_OKAY);
    pins(9'h1c3);
    wr(`EIS_ADDR_FLAGS, 32'h0000_0002);
    pins(9'h1e3);
    rdc(`EIS_ADDR_FLAGS, 32'h0000_0000, `EIS_RESP_OKAY);
    pins(9'h1f3);
    rdc(`EIS_ADDR_FLAGS, 32'h0000_0004, `EIS_RESP_OKAY);
    pins(9'h1c3);
    wr(`EIS_ADDR_FLAGS, 32'h0000_0004);
    pins(9'h1c1);
    rdc(`EIS_ADDR_FLAGS, 32'h0000_0000, `EIS_RESP_OKAY);
    pins(9'h1c0);
    rdc(`EIS_ADDR_FLAGS, 32'h0000_0001, `EIS_RESP_OKAY);
    wr(`EIS_ADDR_MASK, 32'h0000_0001);
    rdc(`EIS_ADDR_MASK, 32'h0000_0001, `EIS_RESP_OKAY);
    chk(32'(irq), 32'h0000_0001);
    ven <= 4'h2;
    cyc(3);
    chk(32'(req), 32'h0000_0000);
    ven <= 4'h1;
    cyc(3);
    chk(32'(req), 32'h0000_0001);
    ven <= 4'h0;
    wr(`EIS_ADDR_MASK, 32'h0000_0000);
    cyc(3);
    chk(32'(irq), 32'h0000_0000);
    pins(9'h1c3);
    wr(`EIS_ADDR_FLAGS, 32'h0000_0001);
    rdc(`EIS_ADDR_FLAGS, 32'h0000_0000, `EIS_RESP_OKAY);
    // Ch1 turned low-active with its pins low
    wr(`EIS_ADDR_POLARITY, 32'h0000_0004);
    cyc(8);
    rdc(`EIS_ADDR_FLAGS, 32'h0000_0002, `EIS_RESP_OKAY);
    chk(32'(comb), 32'h0000_0002);
    // Ch2 on its upper pin alone, ch0 with nothing selected
    sel <= 9'h1ec;
    pins(9'h1e3);
    rdc(`EIS_ADDR_FLAGS, 32'h0000_0006, `EIS_RESP_OKAY);
    chk(32'(comb), 32'h0000_0006);
    conclude();
  end
endmodule
`default_nettype wire
